// [design/uart_status_pkg.sv]
// Package with register map, field positions, reset values and carrier types for the serial channel status logic.
package uart_status_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] LINE_STATUS_ADDR      = 8'h00;
    localparam logic [7:0] MODEM_STATUS_ADDR     = 8'h04;
    localparam logic [7:0] MODEM_CONTROL_ADDR    = 8'h08;
    localparam logic [7:0] ENHANCED_FEATURE_ADDR = 8'h0C;
    localparam logic [7:0] IRQ_STATUS_ADDR       = 8'h10;
    localparam logic [7:0] IRQ_MASK_ADDR         = 8'h14;
    localparam logic [7:0] RX_DATA_ADDR          = 8'h18;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LS_READY_BIT   = 0;
    localparam int LS_OVERRUN_BIT = 1;
    localparam int LS_PARITY_BIT  = 2;
    localparam int MC_DTR_BIT     = 0;
    localparam int MC_RTS_BIT     = 1;
    localparam int MC_OUT1_BIT    = 2;
    localparam int MC_OUT2_BIT    = 3;
    localparam int MC_LOOP_BIT    = 4;
    localparam int EF_AUTO_CTS_BIT = 7;
    localparam int IRQ_PARITY_BIT  = 0;
    localparam int IRQ_OVERRUN_BIT = 1;
    localparam int IRQ_MODEM_BIT   = 2;

    // ------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------
    localparam logic [7:0]  MODEM_CONTROL_RST    = 8'h00;
    localparam logic [7:0]  ENHANCED_FEATURE_RST = 8'h00;
    localparam logic [2:0]  IRQ_MASK_RST         = 3'h0;
    localparam int          FIFO_DEPTH           = 16;
    localparam logic [4:0]  FIFO_DEPTH_CNT       = 5'h10;
    localparam logic [1:0]  RESP_OKAY            = 2'h0;
    localparam logic [1:0]  RESP_SLVERR          = 2'h2;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       parityErr;
    } rx_char_t;

    typedef struct packed {
        logic cdN;
        logic riN;
        logic dsrN;
        logic ctsN;
    } modem_in_t;

endpackage : uart_status_pkg

// [design/modem_sync.sv]
// Two-stage synchroniser for the four active-low modem control inputs.
`timescale 1ns/1ps
module modem_sync
    import uart_status_pkg::*;
(
    // Clock and reset
    input  wire logic      clk,
    input  wire logic      rst,
    // Pins and synchronised copy
    input  wire modem_in_t pinsIn,
    output modem_in_t      pinsSync
);

    modem_in_t stage1_q;
    modem_in_t stage2_q;

    // Inactive pins are high, so reset to all ones; stage one feeds only stage two.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1_q <= '1;
            stage2_q <= '1;
        end else begin
            stage1_q <= pinsIn;
            stage2_q <= stage1_q;
        end
    end

    assign pinsSync = stage2_q;

endmodule : modem_sync

// [design/rx_fifo.sv]
// Receive FIFO holding characters with their parity error flag.
`timescale 1ns/1ps
module rx_fifo
    import uart_status_pkg::*;
(
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst,
    // Write side
    input  wire rx_char_t wrChar,
    output logic          full,
    // Read side
    input  wire logic     rdPop,
    output rx_char_t      topChar,
    output logic          empty
);

    logic [8:0] mem [FIFO_DEPTH];
    logic [3:0] wrPtr_q, wrPtr_d;
    logic [3:0] rdPtr_q, rdPtr_d;
    logic [4:0] count_q, count_d;
    logic       doWr;
    logic       doRd;

    // Pointer and count updates; a write while full is dropped.
    always_comb begin
        doWr    = wrChar.valid && (count_q != FIFO_DEPTH_CNT);
        doRd    = rdPop && (count_q != 5'h00);
        wrPtr_d = doWr ? wrPtr_q + 4'h1 : wrPtr_q;
        rdPtr_d = doRd ? rdPtr_q + 4'h1 : rdPtr_q;
        count_d = count_q + {4'h0, doWr} - {4'h0, doRd};
    end

    // Pointer registers.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_q <= 4'h0;
            rdPtr_q <= 4'h0;
            count_q <= 5'h00;
        end else begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end

    // Storage array, written without reset.
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_q] <= {wrChar.data, wrChar.parityErr};
        end
    end

    assign full    = (count_q == FIFO_DEPTH_CNT);
    assign empty   = (count_q == 5'h00);
    assign topChar = '{valid: !empty, data: mem[rdPtr_q][8:1], parityErr: mem[rdPtr_q][0]};

endmodule : rx_fifo

// [design/uart_line_modem_status.sv]
// Line and modem status logic of one serial channel with an AXI4-Lite register slave.
//
// Summary of operation
// - A character received with bad parity raises the parity error bit, which follows the character at the FIFO top.
// - A character completing while the receive FIFO is full raises the overrun error bit.
// - On overrun the new character is dropped and the FIFO contents stay intact.
// - Data ready reads one while any received byte is held and zero when none remains.
// - Four modem change flags set on input changes and all clear when modem status is read.
// - Bit 7 shows the inverted carrier detect pin, or user output two in loop-back.
// - Bit 6 shows the inverted ring indicator pin, or user output one in loop-back.
// - Bit 5 shows the inverted data set ready pin, or the DTR control bit in loop-back.
// - Bit 4 shows the inverted clear-to-send pin, or the RTS control bit in loop-back.
// - With automatic clear-to-send on, a high clear-to-send pin stops transmission after the current character.
// - Carrier, data set ready and clear-to-send change flags set on any toggle since the last read.
// - The ring change flag sets only when the ring pin goes from zero to one.
// - A modem status interrupt cause sets while any change flag is set and stays until a one is written to it with all change flags clear.
// - Automatic clear-to-send stopping works only when enhanced feature bit 7 is one.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module uart_line_modem_status
    import uart_status_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // AXI4-Lite write channels
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read channels
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Receiver character strobe
    input  wire rx_char_t    rxChar,
    // Modem pins, active low
    input  wire modem_in_t   modemPins,
    // Transmitter gating
    input  wire logic        txCharDone,
    output logic             txHold,
    // Interrupt
    output logic             irq
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    // Submodule links.
    modem_in_t   pinsSync;
    rx_char_t    topChar;
    logic        fifoFull;
    logic        fifoEmpty;
    logic        fifoPop;

    // Software registers.
    logic [7:0]  modemCtrl_q, modemCtrl_d;
    logic [7:0]  enhFeat_q, enhFeat_d;
    logic [2:0]  irqMask_q, irqMask_d;

    // Event state.
    logic [2:0]  irqStat_q, irqStat_d;
    logic        overrun_q, overrun_d;
    logic [3:0]  delta_q, delta_d;
    logic [3:0]  levelPrev_q, levelPrev_d;
    logic [3:0]  modemLevel;
    logic        txHold_q, txHold_d;
    logic        irq_q, irq_d;

    // Bus channel state.
    logic        awHeld_q, awHeld_d;
    logic        wHeld_q, wHeld_d;
    logic [7:0]  awAddr_q, awAddr_d;
    logic [31:0] wData_q, wData_d;
    logic        bValid_q, bValid_d;
    logic [1:0]  bResp_q, bResp_d;
    logic        rValid_q, rValid_d;
    logic [31:0] rData_q, rData_d;
    logic [1:0]  rResp_q, rResp_d;

    // Decoded accesses.
    logic        wrFire;
    logic        rdFire;
    logic        lineRd;
    logic        modemRd;
    logic        loopback;

    // Register views.
    logic [7:0]  lineStatus;
    logic [7:0]  modemStatus;

    // Byte lane 0 write check shared by all control registers.
    function automatic logic laneWrite(input logic [7:0] addr, input logic [7:0] target, input logic [3:0] strb);
        return (addr == target) && strb[0];
    endfunction : laneWrite

    // True for an aligned address that names a register.
    function automatic logic addrMapped(input logic [7:0] addr);
        return (addr <= RX_DATA_ADDR) && (addr[1:0] == 2'h0);
    endfunction : addrMapped

    // ------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------
    modem_sync u_sync (
        .clk      (clk),
        .rst      (rst),
        .pinsIn   (modemPins),
        .pinsSync (pinsSync)
    );

    rx_fifo u_fifo (
        .clk     (clk),
        .rst     (rst),
        .wrChar  (rxChar),
        .full    (fifoFull),
        .rdPop   (fifoPop),
        .topChar (topChar),
        .empty   (fifoEmpty)
    );

    // ------------------------------------------------------------
    // Status composition
    // ------------------------------------------------------------
    // Loop-back substitutes control outputs, otherwise the pins are inverted.
    always_comb begin
        loopback = modemCtrl_q[MC_LOOP_BIT];
        if (loopback) begin
            modemLevel = {modemCtrl_q[MC_OUT2_BIT],
                          modemCtrl_q[MC_OUT1_BIT],
                          modemCtrl_q[MC_DTR_BIT],
                          modemCtrl_q[MC_RTS_BIT]};
        end else begin
            modemLevel = ~{pinsSync.cdN, pinsSync.riN, pinsSync.dsrN, pinsSync.ctsN};
        end
        modemStatus = {modemLevel, delta_q};

        // Low receive bits of line status.
        lineStatus  = 8'h00;
        lineStatus[LS_PARITY_BIT]  = topChar.valid && topChar.parityErr;
        lineStatus[LS_OVERRUN_BIT] = overrun_q;
        lineStatus[LS_READY_BIT]   = !fifoEmpty;
    end

    // ------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------
    // Address and data are held independently until both are present.
    always_comb begin
        awHeld_d = awHeld_q;
        wHeld_d  = wHeld_q;
        awAddr_d = awAddr_q;
        wData_d  = wData_q;
        bValid_d = bValid_q;
        bResp_d  = bResp_q;
        if (s_axi_awvalid && s_axi_awready) begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
        end

        // Both halves held and no answer pending.
        wrFire = awHeld_q && wHeld_q && !bValid_q;
        if (wrFire) begin
            awHeld_d = 1'b0;
            wHeld_d  = 1'b0;
            bValid_d = 1'b1;
            bResp_d  = addrMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (bValid_q && s_axi_bready) begin
            bValid_d = 1'b0;
        end
    end

    // Strobes are captured alongside data so byte lane 0 gates writes.
    logic [3:0] wStrb_q, wStrb_d;
    always_comb begin
        wStrb_d = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wStrb_q;
    end

    // Read answer one cycle after the address is taken.
    always_comb begin
        rValid_d = rValid_q;
        rData_d  = rData_q;
        rResp_d  = rResp_q;
        rdFire   = s_axi_arvalid && !rValid_q;
        if (rdFire) begin
            rValid_d = 1'b1;
            rResp_d  = RESP_OKAY;
            unique case (s_axi_araddr)
                LINE_STATUS_ADDR:      rData_d = {24'h000000, lineStatus};
                MODEM_STATUS_ADDR:     rData_d = {24'h000000, modemStatus};
                MODEM_CONTROL_ADDR:    rData_d = {24'h000000, modemCtrl_q};
                ENHANCED_FEATURE_ADDR: rData_d = {24'h000000, enhFeat_q};
                IRQ_STATUS_ADDR:       rData_d = {29'h0000000, irqStat_q};
                IRQ_MASK_ADDR:         rData_d = {29'h0000000, irqMask_q};
                RX_DATA_ADDR:          rData_d = {24'h000000, topChar.valid ? topChar.data : 8'h00};
                default: begin
                    rData_d = 32'h00000000;
                    rResp_d = RESP_SLVERR;
                end
            endcase
        end else if (rValid_q && s_axi_rready) begin
            rValid_d = 1'b0;
        end

        // Read side effects land in the take cycle.
        lineRd  = rdFire && (s_axi_araddr == LINE_STATUS_ADDR);
        modemRd = rdFire && (s_axi_araddr == MODEM_STATUS_ADDR);
        fifoPop = rdFire && (s_axi_araddr == RX_DATA_ADDR);
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    // Software-written control, enhanced feature and mask registers.
    always_comb begin
        modemCtrl_d = modemCtrl_q;
        enhFeat_d   = enhFeat_q;
        irqMask_d   = irqMask_q;
        if (wrFire && laneWrite(awAddr_q, MODEM_CONTROL_ADDR, wStrb_q)) begin
            modemCtrl_d = wData_q[7:0];
        end
        if (wrFire && laneWrite(awAddr_q, ENHANCED_FEATURE_ADDR, wStrb_q)) begin
            enhFeat_d = wData_q[7:0];
        end
        if (wrFire && laneWrite(awAddr_q, IRQ_MASK_ADDR, wStrb_q)) begin
            irqMask_d = wData_q[2:0];
        end
    end

    // ------------------------------------------------------------
    // Event flags and interrupt
    // ------------------------------------------------------------
    // Change detection, overrun, sticky interrupt status; every set wins over its clear.
    always_comb begin
        levelPrev_d = modemLevel;
        delta_d     = modemRd ? 4'h0 : delta_q;
        delta_d[3]  = delta_d[3] | (modemLevel[3] ^ levelPrev_q[3]);
        // Ring flag on its pin rising.
        delta_d[2]  = delta_d[2] | (~modemLevel[2] & levelPrev_q[2]);
        delta_d[1]  = delta_d[1] | (modemLevel[1] ^ levelPrev_q[1]);
        delta_d[0]  = delta_d[0] | (modemLevel[0] ^ levelPrev_q[0]);

        overrun_d   = (lineRd ? 1'b0 : overrun_q) | (rxChar.valid & fifoFull);

        // Sticky causes; writing a one clears.
        irqStat_d   = irqStat_q;
        if (wrFire && laneWrite(awAddr_q, IRQ_STATUS_ADDR, wStrb_q)) begin
            irqStat_d = irqStat_q & ~wData_q[2:0];
        end
        irqStat_d[IRQ_PARITY_BIT]  = irqStat_d[IRQ_PARITY_BIT] | (rxChar.valid & rxChar.parityErr);
        irqStat_d[IRQ_OVERRUN_BIT] = irqStat_d[IRQ_OVERRUN_BIT] | (rxChar.valid & fifoFull);
        irqStat_d[IRQ_MODEM_BIT]   = irqStat_d[IRQ_MODEM_BIT] | (|delta_d);
        irq_d = |(irqStat_d & irqMask_d);
    end

    // Transmit hold: taken only at a character boundary, released when clear-to-send returns.
    always_comb begin
        txHold_d = txHold_q;
        if (!enhFeat_q[EF_AUTO_CTS_BIT] || !pinsSync.ctsN) begin
            txHold_d = 1'b0;
        end else if (txCharDone || !txHold_q) begin
            txHold_d = txCharDone ? 1'b1 : txHold_q;
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    // Register every group of state.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modemCtrl_q <= MODEM_CONTROL_RST;
            enhFeat_q   <= ENHANCED_FEATURE_RST;
            irqMask_q   <= IRQ_MASK_RST;
            irqStat_q   <= 3'h0;
            overrun_q   <= 1'b0;
            delta_q     <= 4'h0;
            levelPrev_q <= 4'h0;
            txHold_q    <= 1'b0;
            irq_q       <= 1'b0;
            awHeld_q    <= 1'b0;
            wHeld_q     <= 1'b0;
            awAddr_q    <= 8'h00;
            wData_q     <= 32'h00000000;
            wStrb_q     <= 4'h0;
            bValid_q    <= 1'b0;
            bResp_q     <= RESP_OKAY;
            rValid_q    <= 1'b0;
            rData_q     <= 32'h00000000;
            rResp_q     <= RESP_OKAY;
        end else begin
            modemCtrl_q <= modemCtrl_d;
            enhFeat_q   <= enhFeat_d;
            irqMask_q   <= irqMask_d;
            irqStat_q   <= irqStat_d;
            overrun_q   <= overrun_d;
            delta_q     <= delta_d;
            levelPrev_q <= levelPrev_d;
            txHold_q    <= txHold_d;
            irq_q       <= irq_d;
            awHeld_q    <= awHeld_d;
            wHeld_q     <= wHeld_d;
            awAddr_q    <= awAddr_d;
            wData_q     <= wData_d;
            wStrb_q     <= wStrb_d;
            bValid_q    <= bValid_d;
            bResp_q     <= bResp_d;
            rValid_q    <= rValid_d;
            rData_q     <= rData_d;
            rResp_q     <= rResp_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Readies stay low while a write answer waits.
    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready  = !wHeld_q && !bValid_q;
    assign s_axi_bvalid  = bValid_q;
    assign s_axi_bresp   = bResp_q;
    assign s_axi_arready = !rValid_q;
    assign s_axi_rvalid  = rValid_q;
    assign s_axi_rdata   = rData_q;
    assign s_axi_rresp   = rResp_q;
    assign txHold        = txHold_q;
    assign irq           = irq_q;

endmodule : uart_line_modem_status

// [test/uart_line_modem_status_chk.sv]
// Concurrent checks on the bus handshakes and transmit gating of the status block.
`timescale 1ns/1ps
module uart_line_modem_status_chk
    import uart_status_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    // Transmit gating
    input wire modem_in_t   modemPins,
    input wire logic        txCharDone,
    input wire logic        txHold
);
    // All checks share the one clock and stay quiet during reset.
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    wr_resp_a:
        assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response late");
    resp_busy_a:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
    rd_resp_a:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read data late");
    rd_block_a:
        assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    rd_err_a:
        assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr > 8'h18 || s_axi_araddr[1:0] != 2'h0)
            |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0) else $error("unmapped read not refused");
    rd_ok_a:
        assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= 8'h18 && s_axi_araddr[1:0] == 2'h0
            |=> s_axi_rresp == RESP_OKAY) else $error("mapped read refused");
    hold_cause_a:
        assert property ($rose(txHold) |-> $past(txCharDone)) else $error("hold without a finished character");
    hold_free_a:
        assert property (!modemPins.ctsN [*4] |=> !txHold) else $error("hold kept while clear to send");
endmodule : uart_line_modem_status_chk

bind uart_line_modem_status uart_line_modem_status_chk chk_inst (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .modemPins, .txCharDone, .txHold);

// [test/modem_peer.sv]
// Behavioural modem that drives the active-low control pins.
`timescale 1ns/1ps
module modem_peer
    import uart_status_pkg::*;
(
    // Clock
    input  wire logic      clk,
    // Wanted levels and pins
    input  wire modem_in_t want,
    output modem_in_t      pins
);
    // Pins idle high and follow the wanted levels one cycle later.
    initial pins = 4'hF;
    always @(posedge clk) begin
        pins <= want;
    end
endmodule : modem_peer

// [test/test_uart_line_modem_status.sv]
// Self-checking bench for the line and modem status block.
`timescale 1ns/1ps
module test_uart_line_modem_status;
    import uart_status_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, txCharDone = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, txHold, irq;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    rx_char_t    rxChar = '0;
    modem_in_t   want = 4'hF, modemPins;
    int          error_cnt = 0, cmp_count = 0;
    logic [31:0] seed = 32'hC57D, v;
    logic [7:0]  q[$];
    logic [3:0]  m, o;

    // Clock of 8 ns.
    always #4 clk = ~clk;

    // Design and modem model.
    uart_line_modem_status uart_line_modem_status_inst (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .rxChar, .modemPins, .txCharDone, .txHold, .irq);
    modem_peer modem_peer_inst (.clk, .want, .pins(modemPins));

    // Xorshift source with a fixed start.
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Change flags expected: any toggle, ring only when its pin rises.
    function automatic logic [3:0] dExp(input logic [3:0] a, b);
        logic [3:0] f;
        f = a ^ b;
        f[2] = ~a[2] & b[2];
        return f;
    endfunction : dExp

    // Loop-back levels expected from modem control bits.
    function automatic logic [3:0] loopExp(input logic [3:0] c);
        return {c[3], c[2], c[0], c[1]};
    endfunction : loopExp

    // Counts the compare and reports a mismatch.
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test(input bit hung);
        if (hung) error_cnt++;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    // Bus write; address and data are released as each is taken.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (s_axi_bvalid) break;
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (n >= 100) stop_test(1'b1);
        r = s_axi_bresp;
    endtask : wr

    // Bus read; data and response are taken at the valid edge.
    task automatic rd(input logic [7:0] a);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clk);
            if (s_axi_rvalid) break;
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (n >= 100) stop_test(1'b1);
        v = s_axi_rdata;
        r = s_axi_rresp;
    endtask : rd

    // Reads a register and compares the whole word.
    task automatic see(input string nm, input logic [7:0] a, e);
        rd(a);
        chk(nm, v, {24'h0, e});
    endtask : see

    // One received character, followed by an idle cycle.
    task automatic push(input logic [7:0] d, input logic p);
        rxChar <= {1'b1, d, p};
        @(posedge clk);
        rxChar <= '0;
        @(posedge clk);
    endtask : push

    // One transmitter completion pulse.
    task automatic pulse();
        txCharDone <= 1'b1;
        @(posedge clk);
        txCharDone <= 1'b0;
        @(posedge clk);
    endtask : pulse

    // Main sequence.
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        see("line_status", LINE_STATUS_ADDR, 8'h00);
        see("modem_status", MODEM_STATUS_ADDR, 8'h00);
        rd(8'h1C);
        chk("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h1C, 32'h0);
        chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
        $display("done: reset");
        push(8'hA5, 1'b1);
        push(8'h3C, 1'b0);
        see("ls parity", LINE_STATUS_ADDR, 8'h05);
        see("rx data", RX_DATA_ADDR, 8'hA5);
        see("ls clean", LINE_STATUS_ADDR, 8'h01);
        see("rx data", RX_DATA_ADDR, 8'h3C);
        see("ls empty", LINE_STATUS_ADDR, 8'h00);
        $display("done: parity");
        for (int i = 0; i < 17; i++) begin
            v = rnd();
            if (i < 16) q.push_back(v[7:0]);
            push(v[7:0], 1'b0);
        end
        see("ls overrun", LINE_STATUS_ADDR, 8'h03);
        see("ls reread", LINE_STATUS_ADDR, 8'h01);
        foreach (q[i]) see("rx fifo", RX_DATA_ADDR, q[i]);
        see("ls drained", LINE_STATUS_ADDR, 8'h00);
        $display("done: overrun");
        wr(IRQ_MASK_ADDR, 32'h4);
        for (int i = 0; i < 16; i++) begin
            v = rnd();
            o = want;
            m = (i < 8) ? (o ^ (4'h1 << i[1:0])) : v[3:0];
            want <= m;
            repeat (8) @(posedge clk);
            chk("irq", {31'h0, irq}, {31'h0, dExp(o, m) != 4'h0});
            see("flags", MODEM_STATUS_ADDR, {~m, dExp(o, m)});
            see("flags reread", MODEM_STATUS_ADDR, {~m, 4'h0});
            wr(IRQ_STATUS_ADDR, 32'h4);
            repeat (2) @(posedge clk);
            chk("irq cleared", {31'h0, irq}, 32'h0);
        end
        $display("done: modem flags");
        for (int k = 0; k < 16; k++) begin
            wr(MODEM_CONTROL_ADDR, {27'h0, 1'b1, k[3:0]});
            repeat (4) @(posedge clk);
            rd(MODEM_STATUS_ADDR);
            chk("loop", {28'h0, v[7:4]}, {28'h0, loopExp(k[3:0])});
        end
        wr(MODEM_CONTROL_ADDR, 32'h0);
        $display("done: loop-back");
        wr(ENHANCED_FEATURE_ADDR, 32'h80);
        want <= 4'hF;
        repeat (6) @(posedge clk);
        pulse();
        chk("hold on", {31'h0, txHold}, 32'h1);
        want <= 4'hE;
        repeat (6) @(posedge clk);
        chk("hold off", {31'h0, txHold}, 32'h0);
        wr(ENHANCED_FEATURE_ADDR, 32'h0);
        want <= 4'hF;
        repeat (6) @(posedge clk);
        pulse();
        chk("hold disabled", {31'h0, txHold}, 32'h0);
        $display("done: auto clear-to-send");
        stop_test(1'b0);
    end
endmodule : test_uart_line_modem_status
